// *** verilog/rcw_regs.vh ***
// register offsets, field layout, reset values and counts of the calendar/trim/alarm slice
`ifndef RCW_REGS_VH
`define RCW_REGS_VH

`define RCW_ADDR_DAY 4'h4
`define RCW_ADDR_MONTH 4'h5
`define RCW_ADDR_YEAR 4'h6
`define RCW_ADDR_TRIM 4'h7
`define RCW_ADDR_WMIN 4'h8
`define RCW_ADDR_WHOUR 4'h9
`define RCW_ADDR_WDAYS 4'hA

`define RCW_TRIM_LOCK_BIT 7
`define RCW_TRIM_DIR_BIT 6
`define RCW_CENTURY_BIT 7

`define RCW_DAY_RESET 6'h01
`define RCW_MONTH_RESET 5'h01
`define RCW_YEAR_RESET 8'h00
`define RCW_TRIM_RESET 7'h00
`define RCW_WMIN_RESET 7'h00
`define RCW_WHOUR_RESET 6'h00
`define RCW_WDAYS_RESET 7'h00

`define RCW_SEC_BASE_CYCLES 17'h0_8000
`define RCW_CNT_W 17

`endif

// *** verilog/rcw_cal_step.v ***
// one-day advance of the bcd calendar: day, month, year and century toggle
`timescale 1ns/1ps
module rcw_cal_step (
    day_in,
    month_in,
    year_in,
    century_in,
    day_out,
    month_out,
    year_out,
    century_out
);
    input wire [5:0] day_in;
    input wire [4:0] month_in;
    input wire [7:0] year_in;
    input wire century_in;
    output reg [5:0] day_out;
    output reg [4:0] month_out;
    output reg [7:0] year_out;
    output reg century_out;

    reg [5:0] last_day;
    reg leap;
    reg [7:0] day_inc;
    reg [7:0] month_inc;

    // bcd increment of an 8-bit two-digit value, no wrap handling
    function [7:0] bcd_inc;
        input [7:0] v;
        begin
            if (v[3:0] == 4'h9) begin
                bcd_inc = {v[7:4] + 4'h1, 4'h0};
            end else begin
                bcd_inc = {v[7:4], v[3:0] + 4'h1};
            end
        end
    endfunction

    always @* begin
        day_inc = bcd_inc({2'b00, day_in});
        month_inc = bcd_inc({3'b000, month_in});
        // divisible by four: even tens with units 0/4/8, odd tens with units 2/6
        if (year_in[4] == 1'b0) begin
            leap = (year_in[3:0] == 4'h0) || (year_in[3:0] == 4'h4) || (year_in[3:0] == 4'h8);
        end else begin
            leap = (year_in[3:0] == 4'h2) || (year_in[3:0] == 4'h6);
        end
        case (month_in)
            5'h02: last_day = leap ? 6'h29 : 6'h28;
            5'h04, 5'h06, 5'h09, 5'h11: last_day = 6'h30;
            default: last_day = 6'h31;
        endcase
        day_out = day_in;
        month_out = month_in;
        year_out = year_in;
        century_out = century_in;
        if (day_in == last_day) begin
            day_out = 6'h01;
            if (month_in == 5'h12) begin
                month_out = 5'h01;
                if (year_in == 8'h99) begin
                    year_out = 8'h00;
                    century_out = ~century_in;
                end else begin
                    year_out = bcd_inc(year_in);
                end
            end else begin
                month_out = month_inc[4:0];
            end
        end else begin
            day_out = day_inc[5:0];
        end
    end
endmodule

// *** verilog/rcw_top.v ***
// calendar counters, rate trimming second divider and weekly alarm of the real-time clock
`timescale 1ns/1ps
`include "rcw_regs.vh"

// Notes on behaviour
// - year is eight-bit bcd read/write register
// - day limit 31 or 30 by month
// - february ends at 29 leap, 28 otherwise
// - day wrap increments month
// - month runs 1..12, wrap increments year
// - year 00..99, multiples of four leap
// - year wrap 99 to 00 toggles century
// - oscillator stop clears whole trim register
// - second 32768 cycles, trim at 00/20/40
// - direction 0 lengthens by (magnitude-1)*2
// - direction 1 shortens by (~magnitude+1)*2
// - magnitude bits five..one zero: no correction
// - trim write arms trim, skips coinciding boundary
// - alarm minute seven bits, bit7 reads zero
// - alarm hour bits 7..6 zero, bit5 pm/tens
// - 12-hour alarm uses 12/32 midnight/noon encoding
// - alarm day register: seven enables, bit7 zero
// - no day enabled means never match
// - match flag cleared by writing 0 only
module rcw_top (
    sys_clk,
    resetn,
    osc_clk_pin,
    osc_stop_flag,
    divider_reset,
    day_carry,
    cur_seconds,
    cur_minute,
    cur_hour,
    cur_weekday,
    walarm_enable,
    walarm_flag_wr,
    walarm_flag_wdata,
    reg_addr,
    reg_wr,
    reg_wdata,
    reg_rdata,
    sec_tick,
    walarm_match_flag
);
    input wire sys_clk;
    input wire resetn;
    input wire osc_clk_pin;
    input wire osc_stop_flag;
    input wire divider_reset;
    input wire day_carry;
    input wire [6:0] cur_seconds;
    input wire [6:0] cur_minute;
    input wire [5:0] cur_hour;
    input wire [2:0] cur_weekday;
    input wire walarm_enable;
    input wire walarm_flag_wr;
    input wire walarm_flag_wdata;
    input wire [3:0] reg_addr;
    input wire reg_wr;
    input wire [7:0] reg_wdata;
    output reg [7:0] reg_rdata;
    output reg sec_tick;
    output wire walarm_match_flag;

    // calendar state
    reg [5:0] day_q;
    reg [4:0] month_q;
    reg [7:0] year_q;
    reg century_q;
    wire [5:0] day_next;
    wire [4:0] month_next;
    wire [7:0] year_next;
    wire century_next;

    // trim and divider state
    reg [6:0] trim_q;
    reg trim_armed_q;
    reg [`RCW_CNT_W-1:0] cnt_q;
    reg [`RCW_CNT_W-1:0] len_q;
    reg len_pending_q;

    // oscillator pin synchroniser
    reg osc_meta_q;
    reg osc_sync_q;
    reg osc_prev_q;
    wire osc_tick;

    // weekly alarm state
    reg [6:0] wmin_q;
    reg [5:0] whour_q;
    reg [6:0] wdays_q;
    reg match_prev_q;
    reg wflag_q;
    reg match_now;

    wire trim_wr;
    wire cal_wr;
    wire [7:0] wdays_ext;

    // length of one second for the current trim setting, in oscillator cycles
    // shortening tops out at 124 cycles, far above zero, so no underflow guard
    function [`RCW_CNT_W-1:0] second_len;
        input [6:0] trim;
        input apply;
        begin
            if (!apply || trim[5:1] == 5'b00000) begin
                second_len = `RCW_SEC_BASE_CYCLES;
            end else if (trim[`RCW_TRIM_DIR_BIT] == 1'b0) begin
                second_len = `RCW_SEC_BASE_CYCLES
                    + {10'h000, trim[5:0] - 6'h01, 1'b0};
            end else begin
                second_len = `RCW_SEC_BASE_CYCLES
                    - {9'h000, {1'b0, ~trim[5:0]} + 7'h01, 1'b0};
            end
        end
    endfunction

    // seconds value marks a trimmed second
    function is_trim_second;
        input [6:0] s;
        begin
            is_trim_second = (s == 7'h00) || (s == 7'h20) || (s == 7'h40);
        end
    endfunction

    rcw_cal_step u_step (
        .day_in(day_q),
        .month_in(month_q),
        .year_in(year_q),
        .century_in(century_q),
        .day_out(day_next),
        .month_out(month_next),
        .year_out(year_next),
        .century_out(century_next)
    );

    // a write with the top bit set is ignored so stray frames cannot retrim
    assign trim_wr = reg_wr && (reg_addr == `RCW_ADDR_TRIM)
        && (reg_wdata[`RCW_TRIM_LOCK_BIT] == 1'b0);

    // only calendar writes override a carry; other register traffic must not lose a day
    assign cal_wr = reg_wr && ((reg_addr == `RCW_ADDR_DAY) || (reg_addr == `RCW_ADDR_MONTH)
        || (reg_addr == `RCW_ADDR_YEAR));

    // two flip-flops before the edge detector sees the pin
    // three cycles of latency per edge, small against one oscillator period
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            osc_meta_q <= 1'b0;
            osc_sync_q <= 1'b0;
            osc_prev_q <= 1'b0;
        end else begin
            osc_meta_q <= osc_clk_pin;
            osc_sync_q <= osc_meta_q;
            osc_prev_q <= osc_sync_q;
        end
    end

    assign osc_tick = osc_sync_q && !osc_prev_q;

    // calendar counters: host writes load directly, carry advances one day
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            day_q <= `RCW_DAY_RESET;
            month_q <= `RCW_MONTH_RESET;
            year_q <= `RCW_YEAR_RESET;
            century_q <= 1'b0;
        end else if (cal_wr) begin
            // a write wins over a carry in the same cycle; the host value is what it meant
            case (reg_addr)
                `RCW_ADDR_DAY: day_q <= reg_wdata[5:0];
                `RCW_ADDR_MONTH: begin
                    month_q <= reg_wdata[4:0];
                    century_q <= reg_wdata[`RCW_CENTURY_BIT];
                end
                `RCW_ADDR_YEAR: year_q <= reg_wdata;
                default: begin
                end
            endcase
        end else if (day_carry) begin
            day_q <= day_next;
            month_q <= month_next;
            year_q <= year_next;
            century_q <= century_next;
        end
    end

    // trim register and arm flag
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            trim_q <= `RCW_TRIM_RESET;
            trim_armed_q <= 1'b0;
        end else if (osc_stop_flag) begin
            // stop wins over a write so nothing lands while the crystal is down
            trim_q <= `RCW_TRIM_RESET;
            trim_armed_q <= 1'b0;
        end else if (trim_wr) begin
            trim_q <= reg_wdata[6:0];
            // the arm stays up until reset or stop; later writes only change the value
            trim_armed_q <= 1'b1;
        end
    end

    // second divider; length chosen once the new seconds value is visible
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= {`RCW_CNT_W{1'b0}};
            // the first second after reset runs untrimmed
            len_q <= `RCW_SEC_BASE_CYCLES;
            len_pending_q <= 1'b0;
            sec_tick <= 1'b0;
        end else begin
            sec_tick <= 1'b0;
            if (len_pending_q) begin
                // by now the time counters show the seconds value of the new second
                len_pending_q <= 1'b0;
                // a trim write landing on this boundary leaves the second untrimmed
                len_q <= second_len(trim_q,
                    trim_armed_q && !trim_wr && is_trim_second(cur_seconds));
            end
            if (divider_reset) begin
                cnt_q <= {`RCW_CNT_W{1'b0}};
                len_pending_q <= 1'b1;
            end else if (osc_tick) begin
                if (cnt_q >= len_q - `RCW_CNT_W'd1) begin
                    cnt_q <= {`RCW_CNT_W{1'b0}};
                    sec_tick <= 1'b1;
                    len_pending_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + `RCW_CNT_W'd1;
                end
            end
        end
    end

    // weekly alarm registers; unused top bits are never stored
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wmin_q <= `RCW_WMIN_RESET;
            whour_q <= `RCW_WHOUR_RESET;
            wdays_q <= `RCW_WDAYS_RESET;
        end else if (reg_wr) begin
            case (reg_addr)
                `RCW_ADDR_WMIN: wmin_q <= reg_wdata[6:0];
                `RCW_ADDR_WHOUR: whour_q <= reg_wdata[5:0];
                `RCW_ADDR_WDAYS: wdays_q <= reg_wdata[6:0];
                default: begin
                end
            endcase
        end
    end

    // weekday 7 lands on a zero bit, so an unused weekday code never matches
    assign wdays_ext = {1'b0, wdays_q};

    // hour compared as encoded, so 12/24-hour and 12/32 encodings need no mode input
    always @* begin
        match_now = (cur_minute == wmin_q) && (cur_hour == whour_q)
            && wdays_ext[cur_weekday];
    end

    // flag sets on the rising edge of a match; a set beats a simultaneous clear
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            match_prev_q <= 1'b0;
            wflag_q <= 1'b0;
        end else begin
            match_prev_q <= match_now;
            if (walarm_enable && match_now && !match_prev_q) begin
                wflag_q <= 1'b1;
            end else if (walarm_flag_wr && !walarm_flag_wdata) begin
                wflag_q <= 1'b0;
            end
        end
    end

    // gated live by the enable, so a disabled alarm reads as no match
    assign walarm_match_flag = wflag_q && walarm_enable;

    // registered read data; unmapped addresses read zero
    // data lags the address by one cycle; the host takes it on the second edge
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else begin
            case (reg_addr)
                `RCW_ADDR_DAY: reg_rdata <= {2'b00, day_q};
                `RCW_ADDR_MONTH: reg_rdata <= {century_q, 2'b00, month_q};
                `RCW_ADDR_YEAR: reg_rdata <= year_q;
                `RCW_ADDR_TRIM: reg_rdata <= {1'b0, trim_q};
                `RCW_ADDR_WMIN: reg_rdata <= {1'b0, wmin_q};
                `RCW_ADDR_WHOUR: reg_rdata <= {2'b00, whour_q};
                `RCW_ADDR_WDAYS: reg_rdata <= {1'b0, wdays_q};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule

// *** dv/rcw_top_sva.sv ***
// concurrent checks on the register, tick and weekly alarm ports
`timescale 1ns/1ps
module rcw_top_sva (
    input wire sys_clk,
    input wire resetn,
    input wire osc_stop_flag,
    input wire [6:0] cur_minute,
    input wire [5:0] cur_hour,
    input wire [2:0] cur_weekday,
    input wire walarm_enable,
    input wire walarm_flag_wr,
    input wire walarm_flag_wdata,
    input wire [3:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire sec_tick,
    input wire walarm_match_flag
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic [6:0] wmin_q, wdays_q, trim_q;
    logic [5:0] whour_q;
    // weekday 7 has no enable bit, so it is masked before indexing
    wire hit = cur_minute == wmin_q && cur_hour == whour_q && cur_weekday != 3'h7
        && wdays_q[cur_weekday];
    // shadow copies of the registers, rebuilt from the write port, plus the stop flag for trim
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wmin_q <= 7'h00;
            whour_q <= 6'h00;
            wdays_q <= 7'h00;
            trim_q <= 7'h00;
        end else begin
            if (reg_wr && reg_addr == 4'h8)
                wmin_q <= reg_wdata[6:0];
            if (reg_wr && reg_addr == 4'h9)
                whour_q <= reg_wdata[5:0];
            if (reg_wr && reg_addr == 4'hA)
                wdays_q <= reg_wdata[6:0];
            if (osc_stop_flag)
                trim_q <= 7'h00;
            else if (reg_wr && reg_addr == 4'h7 && !reg_wdata[7])
                trim_q <= reg_wdata[6:0];
        end
    end
    chk_min_read: assert property (
        reg_addr == 4'h8 |=> reg_rdata == {1'b0, $past(wmin_q)})
        else $error("alarm minute readback wrong");
    chk_hour_read: assert property (
        reg_addr == 4'h9 |=> reg_rdata == {2'h0, $past(whour_q)})
        else $error("alarm hour readback wrong");
    chk_days_read: assert property (
        reg_addr == 4'hA |=> reg_rdata == {1'b0, $past(wdays_q)})
        else $error("alarm day readback wrong");
    chk_trim_read: assert property (
        reg_addr == 4'h7 |=> reg_rdata == {1'b0, $past(trim_q)})
        else $error("trim readback wrong");
    chk_tick_pulse: assert property (
        sec_tick |=> !sec_tick)
        else $error("second tick longer than one cycle");
    chk_flag_cause: assert property (
        $rose(walarm_match_flag) && $past(walarm_enable) |-> $past(hit) && !$past(hit, 2))
        else $error("alarm flag rose without a new match");
    chk_no_days: assert property (
        wdays_q == 7'h00 && walarm_enable && !walarm_match_flag |=> !walarm_match_flag)
        else $error("alarm flag set with no day enabled");
    chk_one_keeps: assert property (
        walarm_flag_wr && walarm_flag_wdata && walarm_match_flag
        |=> walarm_match_flag || !walarm_enable)
        else $error("writing one changed the alarm flag");
    chk_zero_clears: assert property (
        walarm_flag_wr && !walarm_flag_wdata && !hit |=> !walarm_match_flag)
        else $error("writing zero did not clear the alarm flag");
endmodule

bind rcw_top rcw_top_sva rcw_top_sva_inst (.sys_clk(sys_clk), .resetn(resetn),
    .osc_stop_flag(osc_stop_flag), .cur_minute(cur_minute), .cur_hour(cur_hour),
    .cur_weekday(cur_weekday), .walarm_enable(walarm_enable), .walarm_flag_wr(walarm_flag_wr),
    .walarm_flag_wdata(walarm_flag_wdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sec_tick(sec_tick),
    .walarm_match_flag(walarm_match_flag));

// *** dv/rcw_host_model.sv ***
// host side: register write and read cycles plus a free running crystal pin
`timescale 1ns/1ps
module rcw_host_model (
    input wire sys_clk,
    input wire [7:0] reg_rdata,
    output logic [3:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic osc_clk_pin
);
    initial begin
        reg_addr = 4'h0;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end
    // crystal runs at half the system rate so one whole second fits in a short run
    initial begin
        osc_clk_pin = 1'b0;
        forever @(negedge sys_clk) osc_clk_pin <= ~osc_clk_pin;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wr <= 1'b1;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // read data is registered, so it is taken one edge after the address
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        @(posedge sys_clk);
        #1 d = reg_rdata;
    endtask
endmodule

// *** dv/tb.sv ***
// self-checking bench: calendar carries, register masks, trim lock, weekly alarm
`timescale 1ns/1ps
module tb;
    logic sys_clk, resetn, osc_stop_flag, divider_reset, day_carry, walarm_enable;
    logic walarm_flag_wr, walarm_flag_wdata, osc_clk_pin, reg_wr, sec_tick, walarm_match_flag;
    logic [6:0] cur_seconds, cur_minute;
    logic [5:0] cur_hour;
    logic [2:0] cur_weekday;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, v;
    logic [31:0] seed;
    int fails, n_compared;
    rcw_top rcw_top_inst (.sys_clk(sys_clk), .resetn(resetn), .osc_clk_pin(osc_clk_pin),
        .osc_stop_flag(osc_stop_flag), .divider_reset(divider_reset), .day_carry(day_carry),
        .cur_seconds(cur_seconds), .cur_minute(cur_minute), .cur_hour(cur_hour),
        .cur_weekday(cur_weekday), .walarm_enable(walarm_enable),
        .walarm_flag_wr(walarm_flag_wr), .walarm_flag_wdata(walarm_flag_wdata),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .sec_tick(sec_tick), .walarm_match_flag(walarm_match_flag));
    rcw_host_model rcw_host_model_inst (.sys_clk(sys_clk), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .osc_clk_pin(osc_clk_pin));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] bcd(input int n);
        return 8'((n / 10) * 16 + n % 10);
    endfunction
    function automatic int last_day(input int m, input int y);
        if (m == 2)
            return (y % 4 == 0) ? 29 : 28;
        return (m == 4 || m == 6 || m == 9 || m == 11) ? 30 : 31;
    endfunction
    // oscillator cycles in a second that starts at 00, 20 or 40 with trim t armed
    function automatic int exp_len(input logic [6:0] t);
        if (t[5:1] == 5'h00)
            return 32768;
        if (!t[6])
            return 32768 + (int'(t[5:0]) - 1) * 2;
        return 32768 - (int'(~t[5:0]) + 1) * 2;
    endfunction
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic date_step(input int d, input int m, input int y, input logic c);
        int nd, nm, ny;
        logic nc;
        nd = (d == last_day(m, y)) ? 1 : d + 1;
        nm = (nd == 1) ? m % 12 + 1 : m;
        ny = (nd == 1 && m == 12) ? (y + 1) % 100 : y;
        nc = c ^ (nd == 1 && m == 12 && y == 99);
        rcw_host_model_inst.wr(4'h6, bcd(y));
        rcw_host_model_inst.wr(4'h5, {c, 7'h00} | bcd(m));
        rcw_host_model_inst.wr(4'h4, bcd(d));
        // an alarm write lands with the carry and must not swallow it
        fork
            rcw_host_model_inst.wr(4'h8, 8'h59);
            begin
                @(posedge sys_clk);
                day_carry <= 1'b1;
                @(posedge sys_clk);
                day_carry <= 1'b0;
            end
        join
        rcw_host_model_inst.rd(4'h4, v);
        chk("day", v, bcd(nd));
        rcw_host_model_inst.rd(4'h5, v);
        chk("month", v, {nc, 7'h00} | bcd(nm));
        rcw_host_model_inst.rd(4'h6, v);
        chk("year", v, bcd(ny));
    endtask
    task automatic flag_wr(input logic b);
        @(posedge sys_clk);
        walarm_flag_wr <= 1'b1;
        walarm_flag_wdata <= b;
        @(posedge sys_clk);
        walarm_flag_wr <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        // one trimmed second takes about 66k cycles, the register tests under a thousand
        #300000;
        fails++;
        finish_test();
    end
    initial begin
        int cd[6][4];
        int dy, mo, yr, n;
        logic [6:0] m;
        logic [7:0] tv;
        logic e;
        cd = '{'{28, 2, 1, 0}, '{28, 2, 0, 1}, '{29, 2, 4, 0}, '{31, 12, 99, 0},
            '{31, 12, 99, 1}, '{30, 4, 7, 0}};
        resetn = 1'b0;
        {osc_stop_flag, divider_reset, day_carry, walarm_enable} = 4'h0;
        {walarm_flag_wr, walarm_flag_wdata} = 2'h0;
        {cur_seconds, cur_minute, cur_hour, cur_weekday} = 23'h00_0000;
        seed = 32'h0000_480C;
        fails = 0;
        n_compared = 0;
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        for (int a = 4; a <= 11; a++) begin
            rcw_host_model_inst.rd(4'(a), v);
            chk("reset value", v, (a == 4 || a == 5) ? 8'h01 : 8'h00);
        end
        rcw_host_model_inst.wr(4'h8, 8'hD9);
        rcw_host_model_inst.wr(4'h9, 8'hF2);
        rcw_host_model_inst.wr(4'hA, 8'hFF);
        rcw_host_model_inst.rd(4'h8, v);
        chk("alarm minute", v, 8'h59);
        rcw_host_model_inst.rd(4'h9, v);
        chk("alarm hour", v, 8'h32);
        rcw_host_model_inst.rd(4'hA, v);
        chk("alarm days", v, 8'h7F);
        rcw_host_model_inst.wr(4'h7, 8'h87);
        rcw_host_model_inst.rd(4'h7, v);
        chk("locked trim", v, 8'h00);
        rcw_host_model_inst.wr(4'h7, 8'h47);
        rcw_host_model_inst.rd(4'h7, v);
        chk("trim", v, 8'h47);
        @(posedge sys_clk);
        osc_stop_flag <= 1'b1;
        rcw_host_model_inst.wr(4'h7, 8'h05);
        osc_stop_flag <= 1'b0;
        rcw_host_model_inst.rd(4'h7, v);
        chk("stopped trim", v, 8'h00);
        seed = xs(seed);
        // bit 1 set keeps the draw away from the no-correction codes
        tv = {1'b0, seed[6:0] | 7'h02};
        rcw_host_model_inst.wr(4'h7, tv);
        // one second runs alongside the register tests; seconds value stays at 00
        fork
            begin
                @(posedge sys_clk);
                divider_reset <= 1'b1;
                @(posedge sys_clk);
                divider_reset <= 1'b0;
                n = 0;
                while (n < 70000 && !sec_tick) begin
                    @(posedge sys_clk);
                    #1;
                    n++;
                end
                // one tick every second cycle, so half the cycle count is the length
                chk("second length", (n + 1) / 2, exp_len(tv[6:0]));
            end
        join_none
        foreach (cd[k])
            date_step(cd[k][0], cd[k][1], cd[k][2], cd[k][3][0]);
        for (int k = 0; k < 30; k++) begin
            seed = xs(seed);
            mo = seed[3:0] % 12 + 1;
            yr = seed[10:4] % 100;
            dy = seed[11] ? last_day(mo, yr) : seed[16:12] % 28 + 1;
            date_step(dy, mo, yr, seed[17]);
        end
        // the flag sets on a rising match only, so each round ends by leaving the match
        for (int i = 0; i < 24; i++) begin
            seed = xs(seed);
            m = (i == 0) ? 7'h00 : seed[6:0];
            rcw_host_model_inst.wr(4'hA, {1'b0, m});
            @(posedge sys_clk);
            cur_minute <= seed[8] ? 7'h59 : 7'h58;
            cur_hour <= seed[9] ? 6'h32 : 6'h12;
            cur_weekday <= seed[12:10];
            walarm_enable <= seed[13] || i < 2;
            repeat (3) @(posedge sys_clk);
            #1;
            e = seed[8] && seed[9] && seed[12:10] != 3'h7 && m[seed[12:10]] && walarm_enable;
            chk("alarm flag", {7'h00, walarm_match_flag}, {7'h00, e});
            flag_wr(1'b1);
            chk("flag after one", {7'h00, walarm_match_flag}, {7'h00, e});
            flag_wr(1'b0);
            chk("flag after zero", {7'h00, walarm_match_flag}, 8'h00);
            @(posedge sys_clk);
            cur_minute <= 7'h00;
        end
        rcw_host_model_inst.rd(4'hF, v);
        chk("unmapped", v, 8'h00);
        wait fork;
        finish_test();
    end
endmodule
